// ---- rtl/ebcr_pkg.sv ----
// package: phase codes, config layout and timing constants for the bus cycle sequencer
package ebcr_pkg;
  // ----------------------------------------------------------------
  // phase states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD = 3'b010,
    ST_WSET = 3'b011,
    ST_ACC = 3'b100,
    ST_RDYW = 3'b101,
    ST_HOLD = 3'b110
  } ebcr_state_t;

  // ----------------------------------------------------------------
  // chip_select_timing_config layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] addr_ext;   // extra setup units on window change, 0..3
    logic addr_len;         // 0: 1 unit, 1: 2 units
    logic [1:0] cmd_len;    // 0..3
    logic wset_len;         // 0..1
    logic [4:0] acc_len;    // value+1 units, 1..32
    logic [1:0] hold_len;   // 0..3
    logic rdy_en;
    logic rdy_async;
    logic rdy_pol;          // 1: ready active high
  } ebcr_cfg_t;

  localparam int CFG_W = 16;
  localparam int AD_W = 24;
  localparam int DAT_W = 16;

  // ----------------------------------------------------------------
  // bus register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;
  // ctrl bits: 0 start, 1 write, 2 multiplexed, 3 window change, 4 upper byte
  localparam int CTL_START = 0;
  localparam int CTL_WRITE = 1;
  localparam int CTL_MUX = 2;
  localparam int CTL_WIN = 3;
  localparam int CTL_UBE = 4;
  localparam logic [CFG_W-1:0] CFG_RST = 16'h7FFA;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage : ebcr_pkg

// ---- rtl/ebcr_top.sv ----
// external bus cycle sequencer with ready handshake and ahb-lite control slave
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Contract
// - every access runs address setup, command delay, write setup, access, hold in order
// - phase lengths come from chip_select_timing_config
// - address setup 1 or 2 units, plus 0..3 on window change
// - command delay 0..3 units, hold 0..3 units
// - write setup / turnaround phase 0 or 1 unit
// - access 1..32 units, stretched by ready when enabled
// - ready polarity is selectable by software
// - synchronous ready taken after two register stages; partner drives it on reference clock
// - asynchronous ready passes a synchroniser, at least one wait state
// - first sample point follows programmed phases, differs sync versus async
// - ready inactive at sample point inserts a wait state and resamples
// - ready active at sample point ends access, cycle completes
// - ready is only evaluated after the programmed access units elapse
// - read data captured on the edge that releases the read strobe
// - separate mode address may change after strobe ends, read data unaffected
// - multiplexed mode puts address then write data on shared lines
// - separate mode drives 24 address lines, data on 16 data lines
// - system clock drives the reference clock output
// ----------------------------------------------------------------
module ebcr_top import ebcr_pkg::*; #(
  parameter int ADDR_W = AD_W,
  parameter int DATA_W = DAT_W
) (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic READY_I,
  input wire logic [DATA_W-1:0] DATA_I,
  output logic [DATA_W-1:0] DATA_O,
  output logic DATA_OE_O,
  output logic [ADDR_W-1:0] ADDR_O,
  output logic CS_N_O,
  output logic ALE_O,
  output logic RD_N_O,
  output logic WR_N_O,
  output logic UPPER_BYTE_ENABLE_N_O,
  output logic REF_CLK_O
);
  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  logic ph_act_r;
  logic ph_wr_r;
  logic [7:0] ph_addr_r;
  logic [CFG_W-1:0] cfg_r;
  logic [ADDR_W-1:0] acc_addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [4:0] ctrl_r;
  logic busy_r;
  logic [DATA_W-1:0] rdata_r;
  logic start_r;
  ebcr_cfg_t cfg;
  wire addr_take = HSEL_I && HREADY_I && HTRANS_I[1];
  // timing and mode may not change under a running cycle
  wire wr_cfg = ph_act_r && ph_wr_r && (ph_addr_r == OFS_CFG) && !busy_r;
  wire wr_addr = ph_act_r && ph_wr_r && (ph_addr_r == OFS_ADDR);
  wire wr_wdat = ph_act_r && ph_wr_r && (ph_addr_r == OFS_WDATA);
  wire wr_ctrl = ph_act_r && ph_wr_r && (ph_addr_r == OFS_CTRL) && !busy_r;
  // a new start while busy is ignored so a running cycle is never restarted
  wire go = wr_ctrl && HWDATA_I[CTL_START] && !busy_r;
  logic [31:0] rd_mux;
  assign cfg = ebcr_cfg_t'(cfg_r);
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  always_comb begin
    case (ph_addr_r)
      OFS_CFG: rd_mux = {16'h0000, cfg_r};
      OFS_ADDR: rd_mux = 32'(acc_addr_r);
      OFS_WDATA: rd_mux = 32'(wdata_r);
      OFS_CTRL: rd_mux = {27'h000_0000, ctrl_r};
      OFS_STAT: rd_mux = {31'h0000_0000, busy_r};
      OFS_RDATA: rd_mux = 32'(rdata_r);
      default: rd_mux = ZERO32;
    endcase
  end
  assign HRDATA_O = (ph_act_r && !ph_wr_r) ? rd_mux : ZERO32;

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ph_act_r <= 1'b0;
      ph_wr_r <= 1'b0;
      ph_addr_r <= 8'h00;
    end else if (CE_I) begin
      ph_act_r <= addr_take;
      ph_wr_r <= HWRITE_I;
      ph_addr_r <= HADDR_I[7:0];
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cfg_r <= CFG_RST;
      acc_addr_r <= '0;
      wdata_r <= '0;
      ctrl_r <= 5'h00;
      start_r <= 1'b0;
    end else if (CE_I) begin
      if (wr_cfg) begin
        cfg_r <= HWDATA_I[CFG_W-1:0];
      end
      if (wr_addr) begin
        acc_addr_r <= HWDATA_I[ADDR_W-1:0];
      end
      if (wr_wdat) begin
        wdata_r <= HWDATA_I[DATA_W-1:0];
      end
      if (wr_ctrl) begin
        ctrl_r <= {HWDATA_I[4:1], 1'b0};
      end
      start_r <= go;
    end
  end

  // ----------------------------------------------------------------
  // ready input conditioning
  // ----------------------------------------------------------------
  // pin synchronisers; the async path adds one stage so sync mode stays shortest
  logic rdy_s1_r;
  logic rdy_s2_r;
  logic rdy_s3_r;
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdy_s1_r <= 1'b0;
      rdy_s2_r <= 1'b0;
      rdy_s3_r <= 1'b0;
    end else if (CE_I) begin
      rdy_s1_r <= READY_I;
      rdy_s2_r <= rdy_s1_r;
      rdy_s3_r <= rdy_s2_r;
    end
  end
  wire rdy_raw = cfg.rdy_async ? rdy_s3_r : rdy_s2_r;
  wire rdy_act = rdy_raw ~^ cfg.rdy_pol;

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  ebcr_state_t st_r;
  ebcr_state_t st_nxt;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [DATA_W-1:0] din_s1_r;
  logic [DATA_W-1:0] din_s2_r;
  wire last = (cnt_r == 6'd0);
  wire [5:0] addr_units = 6'(cfg.addr_len) + (ctrl_r[CTL_WIN] ? 6'(cfg.addr_ext) : 6'd0);
  wire rdy_wait_async = cfg.rdy_en && cfg.rdy_async;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = last ? 6'd0 : cnt_r - 6'd1;
    case (st_r)
      ST_IDLE: begin
        if (start_r) begin
          st_nxt = ST_ADDR;
          cnt_nxt = addr_units;
        end
      end
      ST_ADDR: begin
        if (last) begin
          if (cfg.cmd_len != 2'd0) begin
            st_nxt = ST_CMD;
            cnt_nxt = 6'(cfg.cmd_len) - 6'd1;
          end else if (cfg.wset_len) begin
            st_nxt = ST_WSET;
            cnt_nxt = 6'd0;
          end else begin
            st_nxt = ST_ACC;
            cnt_nxt = 6'(cfg.acc_len);
          end
        end
      end
      ST_CMD: begin
        if (last) begin
          st_nxt = cfg.wset_len ? ST_WSET : ST_ACC;
          cnt_nxt = cfg.wset_len ? 6'd0 : 6'(cfg.acc_len);
        end
      end
      ST_WSET: begin
        st_nxt = ST_ACC;
        cnt_nxt = 6'(cfg.acc_len);
      end
      ST_ACC: begin
        // async mode with ready enabled always owes one ready wait, the synchroniser's extra stage
        if (last) begin
          if (!cfg.rdy_en || (!rdy_wait_async && rdy_act)) begin
            st_nxt = (cfg.hold_len != 2'd0) ? ST_HOLD : ST_IDLE;
            cnt_nxt = 6'(cfg.hold_len) - 6'd1;
          end else begin
            st_nxt = ST_RDYW;
          end
        end
      end
      ST_RDYW: begin
        if (rdy_act) begin
          st_nxt = (cfg.hold_len != 2'd0) ? ST_HOLD : ST_IDLE;
          cnt_nxt = 6'(cfg.hold_len) - 6'd1;
        end else begin
          st_nxt = ST_RDYW;
        end
      end
      ST_HOLD: begin
        if (last) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
        cnt_nxt = 6'd0;
      end
    endcase
  end

  wire acc_end = (st_r inside {ST_ACC, ST_RDYW}) && !(st_nxt inside {ST_ACC, ST_RDYW});
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_r <= ST_IDLE;
      cnt_r <= 6'd0;
      busy_r <= 1'b0;
    end else if (CE_I) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= go || start_r || (st_nxt != ST_IDLE);
    end
  end

  // data pins are asynchronous to the system clock: two stages before use
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      din_s1_r <= '0;
      din_s2_r <= '0;
    end else if (CE_I) begin
      din_s1_r <= DATA_I;
      din_s2_r <= din_s1_r;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata_r <= '0;
    end else if (CE_I && acc_end && !ctrl_r[CTL_WRITE]) begin
      rdata_r <= din_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // outputs register the next phase so strobes change on the same edge as the state
  wire mux_m = ctrl_r[CTL_MUX];
  wire nxt_on = (st_nxt != ST_IDLE);
  wire nxt_cmd = (st_nxt inside {ST_ACC, ST_RDYW});
  wire nxt_dat = ctrl_r[CTL_WRITE] && (st_nxt inside {ST_WSET, ST_ACC, ST_RDYW, ST_HOLD});
  wire nxt_adr_ph = mux_m && (st_nxt == ST_ADDR);
  wire cs_n_nxt = !nxt_on;
  wire ale_nxt = nxt_adr_ph;
  wire rd_n_nxt = !(nxt_cmd && !ctrl_r[CTL_WRITE]);
  wire wr_n_nxt = !(nxt_cmd && ctrl_r[CTL_WRITE]);
  wire ube_n_nxt = !(nxt_on && ctrl_r[CTL_UBE]);
  // separate mode: address dropped when chip select ends, after hold, capture already done
  wire [ADDR_W-1:0] addr_nxt = nxt_on ? acc_addr_r : '0;
  wire [DATA_W-1:0] dout_nxt = nxt_adr_ph ? acc_addr_r[DATA_W-1:0] : wdata_r;
  wire oe_nxt = nxt_adr_ph || nxt_dat;

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      CS_N_O <= 1'b1;
    end else if (CE_I) begin
      CS_N_O <= cs_n_nxt;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ALE_O <= 1'b0;
    end else if (CE_I) begin
      ALE_O <= ale_nxt;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RD_N_O <= 1'b1;
    end else if (CE_I) begin
      RD_N_O <= rd_n_nxt;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      WR_N_O <= 1'b1;
    end else if (CE_I) begin
      WR_N_O <= wr_n_nxt;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      UPPER_BYTE_ENABLE_N_O <= 1'b1;
    end else if (CE_I) begin
      UPPER_BYTE_ENABLE_N_O <= ube_n_nxt;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ADDR_O <= '0;
    end else if (CE_I) begin
      ADDR_O <= addr_nxt;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      DATA_O <= '0;
    end else if (CE_I) begin
      DATA_O <= dout_nxt;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      DATA_OE_O <= 1'b0;
    end else if (CE_I) begin
      DATA_OE_O <= oe_nxt;
    end
  end

  // the system clock itself serves as the bus reference clock
  assign REF_CLK_O = MCLK_I;
endmodule : ebcr_top

// ---- dv/ebcr_chk.sv ----
// checker: bus cycle sequencing properties on the top ports
`timescale 1ns/10ps
module ebcr_chk (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic DATA_OE_O,
  input wire logic CS_N_O,
  input wire logic ALE_O,
  input wire logic RD_N_O,
  input wire logic WR_N_O,
  input wire logic REF_CLK_O
);
  wire stb = !RD_N_O || !WR_N_O;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_strobe_in_cs: assert property (stb |-> !CS_N_O)
    else $error("strobe outside chip select");
  a_one_strobe: assert property (!(!RD_N_O && !WR_N_O))
    else $error("read and write strobe together");
  a_ale_setup_only: assert property (ALE_O |-> !stb && !CS_N_O)
    else $error("latch strobe outside address setup");
  a_setup_first: assert property ($fell(CS_N_O) |-> !stb)
    else $error("strobe on first chip select cycle");
  a_cs_min_len: assert property ($fell(CS_N_O) |=> !CS_N_O)
    else $error("cycle shorter than two units");
  // bound holds only while the far side answers ready within a few units
  a_cycle_ends: assert property ($fell(CS_N_O) |-> ##[1:90] CS_N_O)
    else $error("bus cycle never completed");
  a_read_released: assert property (!RD_N_O |-> !DATA_OE_O)
    else $error("device drives lines during read");
  a_write_drives: assert property (!WR_N_O |-> DATA_OE_O)
    else $error("write data not driven");
  a_ref_clk: assert property (!REF_CLK_O)
    else $error("reference clock not the system clock");
  c_read: cover property ($fell(RD_N_O));
  c_write: cover property ($fell(WR_N_O));
  c_mux: cover property (ALE_O);
endmodule : ebcr_chk
bind ebcr_top ebcr_chk u_chk (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .DATA_OE_O(DATA_OE_O),
  .CS_N_O(CS_N_O), .ALE_O(ALE_O), .RD_N_O(RD_N_O), .WR_N_O(WR_N_O), .REF_CLK_O(REF_CLK_O));

// ---- dv/ebcr_partner.sv ----
// partner: external memory answering strobes with ready and read data
`timescale 1ns/10ps
module ebcr_partner (
  input wire logic clk_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic pol_i,
  input wire logic [3:0] dly_i,
  input wire logic [15:0] rdat_i,
  output logic ready_o,
  output logic [15:0] data_o
);
  logic [4:0] cnt_r;
  wire stb = !rd_n_i || !wr_n_i;
  // ready launched on the reference clock, held until the strobe rises
  always_ff @(posedge clk_i) begin
    cnt_r <= stb ? cnt_r + 5'h01 : 5'h00;
    ready_o <= (stb && cnt_r >= {1'b0, dly_i}) ? pol_i : !pol_i;
  end
  // released lines show the inverse so a stale value is never captured
  assign data_o = (!cs_n_i && wr_n_i) ? rdat_i : ~rdat_i;
endmodule : ebcr_partner

// ---- dv/external_bus_cycle_ready_tb_top.sv ----
// testbench: random bus cycles started over ahb-lite, checked at the pins
`timescale 1ns/10ps
module external_bus_cycle_ready_tb_top import ebcr_pkg::*;;
  typedef struct {int pre; int smin; int smax; int hold; logic [23:0] a; logic [15:0] d;
    logic m; logic u;} ebcr_note_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic hwrite, hready, hresp, ready, oe, cs_n, ale, rd_n, wr_n, ube_n, refclk, pol;
  logic [15:0] dout, pdat, rdat;
  logic [23:0] adr;
  logic [3:0] dly;
  wire [15:0] din = oe ? dout : pdat;
  int err_count = 0;
  int comparisons = 0;
  int seed = 51;
  int pre = 0, s = 0, hd = 0;
  logic act = 1'b0;
  ebcr_note_t q[$], n;
  ebcr_top u_dut (.MCLK_I(clk), .RSTN_I(rst_n), .CE_I(1'b1), .HSEL_I(1'b1), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .READY_I(ready), .DATA_I(din), .DATA_O(dout), .DATA_OE_O(oe), .ADDR_O(adr),
    .CS_N_O(cs_n), .ALE_O(ale), .RD_N_O(rd_n), .WR_N_O(wr_n),
    .UPPER_BYTE_ENABLE_N_O(ube_n), .REF_CLK_O(refclk));
  ebcr_partner u_mem (.clk_i(refclk), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .pol_i(pol), .dly_i(dly), .rdat_i(rdat), .ready_o(ready), .data_o(pdat));
  initial begin
    forever #25 clk = ~clk;
  end
  task print_verdict;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    comparisons++;
    if (v !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, v);
    end
  endtask : chk
  task wt;
    int k;
    k = 0;
    @(posedge clk);
    while (hready !== 1'b1 && k < 50) begin
      k++;
      @(posedge clk);
    end
    if (k == 50) begin
      err_count++;
      print_verdict;
    end
  endtask : wt
  // ----------------------------------------------------------------
  // one ahb-lite single word transfer, held until hready
  // ----------------------------------------------------------------
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    wt();
    htrans <= 2'b00;
    hwdata <= d;
    wt();
    r = hrdata;
  endtask : bus
  // ----------------------------------------------------------------
  // pin monitor: counts phases of each cycle against the oldest note
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    act <= !cs_n;
    if (!cs_n && q.size() > 0) begin
      n = q[0];
      if (!rd_n || !wr_n) s++; else if (s == 0) pre++; else hd++;
      if (ale) chk("mux address", {15'h0000, n.m, n.a[15:0]}, {15'h0000, oe, dout});
      if (!wr_n) chk("write data", {15'h0000, 1'b1, n.d}, {15'h0000, oe, dout});
      if (!n.m && (!rd_n || !wr_n)) chk("address", {8'h00, n.a}, {8'h00, adr});
      chk("upper byte enable", {31'h0000_0000, !n.u}, {31'h0000_0000, ube_n});
    end
    if (cs_n && act && q.size() > 0) begin
      n = q.pop_front();
      chk("setup units", 32'(n.pre), 32'(pre));
      chk("strobe units", 32'(s < n.smin ? n.smin : (s > n.smax ? n.smax : s)), 32'(s));
      chk("hold units", 32'(n.hold), 32'(hd));
      pre = 0;
      s = 0;
      hd = 0;
    end
  end
  initial begin
    logic [31:0] r;
    ebcr_cfg_t c;
    logic [4:0] ctl;
    logic [23:0] wa;
    logic [15:0] wd;
    int k, b, lo, hi, t;
    htrans = 2'b00;
    haddr = ZERO32;
    hwrite = 1'b0;
    hwdata = ZERO32;
    pol = 1'b1;
    dly = 4'h0;
    rdat = 16'h0000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, OFS_CFG, ZERO32, r);
    chk("cfg reset", 32'(CFG_RST), r);
    bus(1'b0, 8'h20, ZERO32, r);
    chk("unmapped", ZERO32, r);
    for (k = 0; k < 40; k++) begin
      c = ebcr_cfg_t'($bits(ebcr_cfg_t)'($random(seed)));
      c.rdy_en = (k % 5) != 0;
      c.rdy_async = (k % 5) > 2;
      c.rdy_pol = k[0];
      c.acc_len = (k == 7) ? 5'h1F : ({2'b00, c.acc_len[2:0]} | 5'h02);
      ctl = 5'($random(seed)) | 5'h01;
      wa = 24'($random(seed));
      wd = 16'($random(seed));
      dly = 4'($random(seed)) & 4'h7;
      rdat = 16'($random(seed));
      pol = c.rdy_pol;
      b = int'(c.acc_len) + 1 + int'(c.rdy_en && c.rdy_async);
      // ready reaches the sequencer 3 edges after launch, 4 in async mode
      hi = int'(dly) + 4 + int'(c.rdy_async);
      lo = (c.rdy_en && hi > b) ? hi : b;
      hi = lo;
      t = int'(c.addr_len) + 1 + (ctl[3] ? int'(c.addr_ext) : 0) + c.cmd_len + c.wset_len;
      bus(1'b1, OFS_CFG, 32'(c), r);
      bus(1'b1, OFS_ADDR, {8'h00, wa}, r);
      bus(1'b1, OFS_WDATA, {16'h0000, wd}, r);
      q.push_back('{t, lo, hi, int'(c.hold_len), wa, wd, ctl[2], ctl[4]});
      bus(1'b1, OFS_CTRL, {27'h000_0000, ctl}, r);
      for (t = 0; q.size() > 0 && t < 200; t++) @(posedge clk);
      if (q.size() > 0) begin
        err_count++;
        print_verdict;
      end
      bus(1'b0, OFS_STAT, ZERO32, r);
      chk("busy", ZERO32, r & 32'h0000_0001);
      if (!ctl[1]) begin
        bus(1'b0, OFS_RDATA, ZERO32, r);
        chk("read data", {16'h0000, rdat}, r);
      end
    end
    print_verdict;
  end
endmodule : external_bus_cycle_ready_tb_top
